// ---- rtl/pfbw_format.sv ----
// Component alignment, swap and little-endian packing stage
module pfbw_format (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] cfa_interp_select,
  input wire logic [1:0] component_align_mode,
  input wire logic outer_component_swap,
  input wire logic in_valid,
  input wire logic in_color,
  input wire logic in_cfa,
  input wire pfbw_pkg::pfbw_depth_type in_depth,
  input wire logic [47:0] in_data,
  input wire logic [2:0] in_nbytes,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_eof,
  output logic out_valid,
  output logic [47:0] out_data,
  output logic [2:0] out_nbytes,
  output logic out_sof,
  output logic out_eol,
  output logic out_eof
);
  import pfbw_pkg::*;

  // ==========================================================
  // Alignment
  function automatic logic [15:0] align_comp(
    input logic [15:0] c,
    input pfbw_depth_type d,
    input logic msb
  );
    logic [15:0] r;
    r = c;
    case (d)
      PFBW_DEPTH_8: r = {8'h00, c[7:0]};
      PFBW_DEPTH_10: r = msb ? {c[9:0], 6'h00} : {6'h00, c[9:0]};
      PFBW_DEPTH_12: r = msb ? {c[11:0], 4'h0} : {4'h0, c[11:0]};
      PFBW_DEPTH_14: r = msb ? {c[13:0], 2'h0} : {2'h0, c[13:0]};
      default: r = c;
    endcase
    return r;
  endfunction

  wire logic cfa_on = (cfa_interp_select == PFBW_CFA_LEGACY) ||
    (cfa_interp_select == PFBW_CFA_ADVANCED);
  wire logic three = in_color | (in_cfa & cfa_on);
  // Colour data cannot stay packed, so it falls back to low alignment
  wire logic raw = (component_align_mode == PFBW_ALIGN_NONE) &&
    !in_color && !cfa_on;
  wire logic msb = (component_align_mode == PFBW_ALIGN_MSB) &&
    !cfa_on;
  wire logic swap = outer_component_swap & three;
  wire logic wide = (in_depth != PFBW_DEPTH_8);
  wire logic [15:0] c0 = align_comp(in_data[15:0], in_depth, msb);
  wire logic [15:0] c1 = align_comp(in_data[31:16], in_depth, msb);
  wire logic [15:0] c2 = align_comp(in_data[47:32], in_depth, msb);
  wire logic [15:0] s0 = swap ? c2 : c0;
  wire logic [15:0] s2 = swap ? c0 : c2;
  // Low byte in the lowest lane gives little-endian memory order
  wire logic [47:0] pk16 = three ? {s2, c1, s0} : {32'h0, c0};
  wire logic [47:0] pk8 = three ?
    {24'h0, s2[7:0], c1[7:0], s0[7:0]} : {40'h0, c0[7:0]};
  wire logic [2:0] nb_cooked = three ? (wide ? 3'h6 : 3'h3) :
    (wide ? 3'h2 : 3'h1);

  // ==========================================================
  // Output stage
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data <= 48'h0;
      out_nbytes <= 3'h0;
      out_sof <= 1'b0;
      out_eol <= 1'b0;
      out_eof <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      out_data <= raw ? in_data : (wide ? pk16 : pk8);
      out_nbytes <= raw ? in_nbytes : nb_cooked;
      out_sof <= in_valid & in_sof;
      out_eol <= in_valid & in_eol;
      out_eof <= in_valid & in_eof;
    end
  end
endmodule

// ---- rtl/pfbw_geom.sv ----
// Whole-line capacity of a buffer and the bottom-up start offset
module pfbw_geom (
  input wire logic [31:0] buf_size,
  input wire logic [31:0] row_len,
  input wire logic [31:0] row_pitch,
  output logic [31:0] line_fit,
  output logic [31:0] bottom_off
);
  import pfbw_pkg::*;

  // ==========================================================
  // Capacity
  wire logic [32:0] num_w = {1'b0, buf_size} + {1'b0, row_pitch};
  wire logic under = (num_w < {1'b0, row_len}) || (row_pitch == 32'h0);
  wire logic [32:0] num = num_w - {1'b0, row_len};
  // Combinational divide; settings only change with no buffers owned
  wire logic [32:0] quo = under ? 33'h0 : num / {1'b0, row_pitch};
  wire logic [63:0] prod = {31'h0, quo} * {32'h0, row_pitch};

  assign line_fit = quo[31:0];
  assign bottom_off = (quo == 33'h0) ? 32'h0 :
    prod[31:0] - row_pitch;
endmodule

// ---- rtl/pfbw_pkg.sv ----
// Shared constants and types for the pixel format buffer writer
package pfbw_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] PFBW_OFF_CTRL = 8'h00;
  localparam logic [7:0] PFBW_OFF_ROW_LEN = 8'h04;
  localparam logic [7:0] PFBW_OFF_ROW_STRIDE = 8'h08;
  localparam logic [7:0] PFBW_OFF_BUF_BASE = 8'h0C;
  localparam logic [7:0] PFBW_OFF_BUF_SIZE = 8'h10;
  localparam logic [7:0] PFBW_OFF_STATUS = 8'h14;
  localparam logic [7:0] PFBW_OFF_WR_PTR = 8'h18;

  // ==========================================================
  // Control field positions
  localparam int PFBW_CTRL_CFA_LSB = 0;
  localparam int PFBW_CTRL_ALIGN_LSB = 2;
  localparam int PFBW_CTRL_SWAP_BIT = 4;
  localparam int PFBW_CTRL_BOTTOM_BIT = 5;
  localparam int PFBW_CTRL_LSCAN_BIT = 6;
  localparam int PFBW_CTRL_WIDTH = 7;
  localparam int PFBW_STAT_DROP_BIT = 0;
  localparam int PFBW_STAT_BUSY_BIT = 1;
  localparam int PFBW_STAT_LINES_LSB = 8;

  // ==========================================================
  // Reset values
  localparam logic [6:0] PFBW_CTRL_RESET = 7'h00;
  localparam logic [31:0] PFBW_LEN_RESET = 32'h0000_0000;
  localparam logic [31:0] PFBW_STRIDE_RESET = 32'h0000_0000;
  localparam logic [31:0] PFBW_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] PFBW_SIZE_RESET = 32'h0000_0000;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    PFBW_CFA_OFF = 2'h0,
    PFBW_CFA_LEGACY = 2'h1,
    PFBW_CFA_ADVANCED = 2'h2
  } pfbw_cfa_type;

  typedef enum logic [1:0] {
    PFBW_ALIGN_LSB = 2'h0,
    PFBW_ALIGN_MSB = 2'h1,
    PFBW_ALIGN_NONE = 2'h2
  } pfbw_align_type;

  typedef enum logic [2:0] {
    PFBW_DEPTH_8 = 3'h0,
    PFBW_DEPTH_10 = 3'h1,
    PFBW_DEPTH_12 = 3'h2,
    PFBW_DEPTH_14 = 3'h3,
    PFBW_DEPTH_16 = 3'h4
  } pfbw_depth_type;

  typedef enum logic [2:0] {
    PFBW_ST_IDLE = 3'b001,
    PFBW_ST_FILL = 3'b010,
    PFBW_ST_DROP = 3'b100
  } pfbw_state_type;

endpackage

// ---- rtl/pfbw_top.sv ----
// Pixel format buffer writer: registers, formatting and DMA addressing
module pfbw_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic in_valid,
  input wire logic in_color,
  input wire logic in_cfa,
  input wire pfbw_pkg::pfbw_depth_type in_depth,
  input wire logic [47:0] in_data,
  input wire logic [2:0] in_nbytes,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_eof,
  output logic dma_wr_valid,
  output logic [31:0] dma_wr_addr,
  output logic [47:0] dma_wr_data,
  output logic [2:0] dma_wr_nbytes,
  output logic buf_done,
  output logic [31:0] buf_done_base
);
  import pfbw_pkg::*;

  // ==========================================================
  // Register storage
  logic [6:0] ctrl_q;
  logic [31:0] len_q;
  logic [31:0] stride_q;
  logic [31:0] base_q;
  logic [31:0] size_q;
  logic drop_q;
  logic [23:0] lines_q;

  // ==========================================================
  // Engine state
  pfbw_state_type state_q;
  pfbw_state_type state_d;
  logic [31:0] cur_base_q;
  logic [31:0] line_off_q;
  logic [31:0] left_q;
  logic [31:0] col_q;
  logic line_ok_q;

  // ==========================================================
  // Control decode
  wire logic [1:0] cfa_interp_select =
    ctrl_q[PFBW_CTRL_CFA_LSB +: 2];
  wire logic [1:0] component_align_mode =
    ctrl_q[PFBW_CTRL_ALIGN_LSB +: 2];
  wire logic outer_component_swap = ctrl_q[PFBW_CTRL_SWAP_BIT];
  wire logic bottom_up_order = ctrl_q[PFBW_CTRL_BOTTOM_BIT];
  wire logic line_scan = ctrl_q[PFBW_CTRL_LSCAN_BIT];
  wire logic [31:0] row_pitch =
    (stride_q == 32'h0) ? len_q : stride_q;

  // ==========================================================
  // Formatter
  logic f_valid;
  logic [47:0] f_data;
  logic [2:0] f_nb;
  logic f_sof;
  logic f_eol;
  logic f_eof;

  pfbw_format u_format (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfa_interp_select(cfa_interp_select),
    .component_align_mode(component_align_mode),
    .outer_component_swap(outer_component_swap),
    .in_valid(in_valid),
    .in_color(in_color),
    .in_cfa(in_cfa),
    .in_depth(in_depth),
    .in_data(in_data),
    .in_nbytes(in_nbytes),
    .in_sof(in_sof),
    .in_eol(in_eol),
    .in_eof(in_eof),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_nbytes(f_nb),
    .out_sof(f_sof),
    .out_eol(f_eol),
    .out_eof(f_eof)
  );

  // ==========================================================
  // Buffer geometry
  logic [31:0] line_fit;
  logic [31:0] bottom_off;

  pfbw_geom u_geom (
    .buf_size(size_q),
    .row_len(len_q),
    .row_pitch(row_pitch),
    .line_fit(line_fit),
    .bottom_off(bottom_off)
  );

  // ==========================================================
  // Beat placement
  wire logic idle = (state_q == PFBW_ST_IDLE);
  wire logic dropping = (state_q == PFBW_ST_DROP);
  wire logic at_line = f_sof | (col_q == 32'h0);
  // A line that cannot fit closes the buffer in line-scan mode
  wire logic reopen = f_valid & line_scan & !f_sof & !idle &
    at_line & (left_q == 32'h0);
  wire logic open_now = f_valid & (f_sof | reopen);
  wire logic [31:0] start_off =
    bottom_up_order ? bottom_off : 32'h0;
  wire logic [31:0] eff_off = open_now ? start_off : line_off_q;
  wire logic [31:0] eff_left = open_now ? line_fit : left_q;
  wire logic [31:0] eff_col = at_line ? 32'h0 : col_q;
  wire logic [31:0] eff_base = open_now ? base_q : cur_base_q;
  wire logic [31:0] end_byte = eff_off + eff_col + {29'h0, f_nb};
  // Top-down area frames may keep a partial last line
  wire logic byte_fit = !line_scan & !bottom_up_order &
    (end_byte <= size_q);
  wire logic line_fits = at_line ? (eff_left != 32'h0) : line_ok_q;
  wire logic beat_ok = (line_fits | byte_fit) &
    !(dropping & !f_sof);
  wire logic live = f_valid & (!idle | f_sof);
  wire logic do_write = live & beat_ok;
  wire logic [31:0] next_off = bottom_up_order ?
    eff_off - row_pitch : eff_off + row_pitch;
  wire logic [31:0] next_left =
    (eff_left == 32'h0) ? 32'h0 : eff_left - 32'h1;
  wire logic [31:0] next_col = eff_col + {29'h0, f_nb};
  wire logic close_now = live & (f_eof | reopen |
    (f_sof & !idle));
  wire logic [31:0] close_base = (f_eof & !reopen) ?
    eff_base : cur_base_q;

  // ==========================================================
  // Engine state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PFBW_ST_IDLE:
      begin
        if (f_valid & f_sof & !f_eof)
        begin
          state_d = beat_ok ? PFBW_ST_FILL : PFBW_ST_DROP;
        end
      end
      PFBW_ST_FILL:
      begin
        if (f_valid & f_eof)
        begin
          state_d = PFBW_ST_IDLE;
        end
        else if (f_valid & !beat_ok & !line_scan)
        begin
          state_d = PFBW_ST_DROP;
        end
      end
      PFBW_ST_DROP:
      begin
        if (f_valid & f_eof)
        begin
          state_d = PFBW_ST_IDLE;
        end
        else if (f_valid & f_sof & beat_ok)
        begin
          state_d = PFBW_ST_FILL;
        end
      end
      default: state_d = PFBW_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= PFBW_ST_IDLE;
      cur_base_q <= 32'h0;
      line_off_q <= 32'h0;
      left_q <= 32'h0;
      col_q <= 32'h0;
      line_ok_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (live)
      begin
        cur_base_q <= eff_base;
        line_ok_q <= line_fits;
        col_q <= f_eol ? 32'h0 : next_col;
        line_off_q <= f_eol ? next_off : eff_off;
        left_q <= f_eol ? next_left : eff_left;
      end
    end
  end

  // ==========================================================
  // DMA write and release outputs
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      dma_wr_valid <= 1'b0;
      dma_wr_addr <= 32'h0;
      dma_wr_data <= 48'h0;
      dma_wr_nbytes <= 3'h0;
      buf_done <= 1'b0;
      buf_done_base <= 32'h0;
    end
    else
    begin
      dma_wr_valid <= do_write;
      dma_wr_addr <= eff_base + eff_off + eff_col;
      dma_wr_data <= f_data;
      dma_wr_nbytes <= f_nb;
      buf_done <= close_now;
      buf_done_base <= close_base;
    end
  end

  // ==========================================================
  // Register writes
  wire logic wr_ctrl = reg_wr & (reg_addr == PFBW_OFF_CTRL);
  wire logic wr_len = reg_wr & (reg_addr == PFBW_OFF_ROW_LEN);
  wire logic wr_stride = reg_wr & (reg_addr == PFBW_OFF_ROW_STRIDE);
  wire logic wr_base = reg_wr & (reg_addr == PFBW_OFF_BUF_BASE);
  wire logic wr_size = reg_wr & (reg_addr == PFBW_OFF_BUF_SIZE);
  wire logic wr_stat = reg_wr & (reg_addr == PFBW_OFF_STATUS);
  wire logic drop_evt = f_valid & live & !beat_ok;
  wire logic line_evt = do_write & f_eol;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= PFBW_CTRL_RESET;
      len_q <= PFBW_LEN_RESET;
      stride_q <= PFBW_STRIDE_RESET;
      base_q <= PFBW_BASE_RESET;
      size_q <= PFBW_SIZE_RESET;
      drop_q <= 1'b0;
      lines_q <= 24'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= reg_wdata[PFBW_CTRL_WIDTH-1:0];
      end
      // Geometry is only safe to change while no buffer is owned
      if (wr_len)
      begin
        len_q <= reg_wdata;
      end
      if (wr_stride)
      begin
        stride_q <= reg_wdata;
      end
      if (wr_base)
      begin
        base_q <= reg_wdata;
      end
      if (wr_size)
      begin
        size_q <= reg_wdata;
      end
      // A new drop in the clearing cycle keeps the flag set
      if (drop_evt)
      begin
        drop_q <= 1'b1;
      end
      else if (wr_stat & reg_wdata[PFBW_STAT_DROP_BIT])
      begin
        drop_q <= 1'b0;
      end
      if (line_evt)
      begin
        lines_q <= lines_q + 24'h1;
      end
    end
  end

  // ==========================================================
  // Register reads
  wire logic [31:0] stat_word = {lines_q, 6'h00, !idle, drop_q};
  wire logic [31:0] wr_ptr = cur_base_q + line_off_q + col_q;
  wire logic [31:0] rd_mux =
    (reg_addr == PFBW_OFF_CTRL) ? {25'h0, ctrl_q} :
    (reg_addr == PFBW_OFF_ROW_LEN) ? len_q :
    (reg_addr == PFBW_OFF_ROW_STRIDE) ? stride_q :
    (reg_addr == PFBW_OFF_BUF_BASE) ? base_q :
    (reg_addr == PFBW_OFF_BUF_SIZE) ? size_q :
    (reg_addr == PFBW_OFF_STATUS) ? stat_word :
    (reg_addr == PFBW_OFF_WR_PTR) ? wr_ptr : 32'h0;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end
endmodule

// ---- verification/pfbw_host_mem.sv ----
// Host memory model that takes the DMA writes and buffer releases
module pfbw_host_mem (
  input wire logic ref_clk,
  input wire logic dma_wr_valid,
  input wire logic [31:0] dma_wr_addr,
  input wire logic [47:0] dma_wr_data,
  input wire logic [2:0] dma_wr_nbytes,
  input wire logic buf_done,
  input wire logic [31:0] buf_done_base
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  int done_cnt = 0;
  logic [31:0] last_base = 32'h0;
  // Unwritten bytes hold a marker so stray or missing writes show up
  task automatic clear();
    foreach (mem[i])
      mem[i] = 8'hEE;
  endtask
  always @(posedge ref_clk)
  begin
    if (dma_wr_valid)
      for (int k = 0; k < 6; k++)
        if (k < dma_wr_nbytes)
          mem[8'(dma_wr_addr + k)] = dma_wr_data[8*k +: 8];
    if (buf_done)
    begin
      done_cnt++;
      last_base = buf_done_base;
    end
  end
endmodule

// ---- verification/pfbw_top_props.sv ----
// Port checker for the pixel format buffer writer
module pfbw_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic in_valid,
  input wire logic in_color,
  input wire logic in_cfa,
  input wire pfbw_pkg::pfbw_depth_type in_depth,
  input wire logic [47:0] in_data,
  input wire logic [2:0] in_nbytes,
  input wire logic in_sof,
  input wire logic in_eof,
  input wire logic dma_wr_valid,
  input wire logic [31:0] dma_wr_addr,
  input wire logic [47:0] dma_wr_data,
  input wire logic [2:0] dma_wr_nbytes,
  input wire logic buf_done
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfbw_pkg::*;
  // ==========================================================
  // Shadow of the control and base registers, taken from the bus
  logic [6:0] ctl_q;
  logic [31:0] base_q;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      ctl_q <= PFBW_CTRL_RESET;
      base_q <= PFBW_BASE_RESET;
    end
    else if (reg_wr && reg_addr == PFBW_OFF_CTRL)
      ctl_q <= reg_wdata[6:0];
    else if (reg_wr && reg_addr == PFBW_OFF_BUF_BASE)
      base_q <= reg_wdata;
  wire logic dec_on = ctl_q[1:0] == 2'h1 || ctl_q[1:0] == 2'h2;
  wire logic [1:0] aln = ctl_q[3:2];
  wire logic swp = ctl_q[4];
  wire logic rgb = in_valid && in_color && !in_cfa && !dec_on;
  wire logic cfa_on = in_valid && in_cfa && dec_on;
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_lsb_fill: assert property (
    rgb && aln == 2'h0 && !swp && in_depth == PFBW_DEPTH_12 ##2 dma_wr_valid
    |-> dma_wr_data[15:0] == {4'h0, $past(in_data[11:0], 2)})
    else $error("low alignment value wrong");
  chk_msb_scale: assert property (
    rgb && aln == 2'h1 && !swp && in_depth == PFBW_DEPTH_10 ##2 dma_wr_valid
    |-> dma_wr_data[15:0] == {$past(in_data[9:0], 2), 6'h00})
    else $error("high alignment value wrong");
  chk_byte_keep: assert property (
    rgb && !swp && in_depth == PFBW_DEPTH_8 ##2 dma_wr_valid
    |-> dma_wr_nbytes == 3'h3 && dma_wr_data[23:0] == {$past(in_data[39:32],
    2), $past(in_data[23:16], 2), $past(in_data[7:0], 2)})
    else $error("byte components altered");
  chk_raw_pass: assert property (
    in_valid && !in_color && !in_cfa && !dec_on && aln == 2'h2 ##2
    dma_wr_valid |-> dma_wr_nbytes == $past(in_nbytes, 2) &&
    dma_wr_data[15:0] == $past(in_data[15:0], 2))
    else $error("packed data altered");
  chk_cfa_low: assert property (
    cfa_on && !swp && in_depth == PFBW_DEPTH_12 ##2 dma_wr_valid
    |-> dma_wr_data[15:0] == {4'h0, $past(in_data[11:0], 2)})
    else $error("decoded data not aligned low");
  chk_swap_outer: assert property (
    ((rgb && aln == 2'h0) || cfa_on) && swp && in_depth == PFBW_DEPTH_12
    ##2 dma_wr_valid |-> dma_wr_data[15:0] == {4'h0, $past(in_data[43:32], 2)})
    else $error("outer components not swapped");
  chk_sof_base: assert property (
    in_valid && in_sof && !ctl_q[5] |-> ##2 dma_wr_valid &&
    dma_wr_addr == $past(base_q, 2))
    else $error("first beat not at buffer base");
  chk_eof_done: assert property (
    in_valid && in_eof |-> ##2 buf_done)
    else $error("buffer not released at end");
  chk_write_cause: assert property (
    dma_wr_valid |-> $past(in_valid, 2))
    else $error("write without input beat");
endmodule

bind pfbw_top pfbw_chk chk_u (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .in_valid(in_valid),
  .in_color(in_color), .in_cfa(in_cfa), .in_depth(in_depth),
  .in_data(in_data), .in_nbytes(in_nbytes), .in_sof(in_sof),
  .in_eof(in_eof), .dma_wr_valid(dma_wr_valid), .dma_wr_addr(dma_wr_addr),
  .dma_wr_data(dma_wr_data), .dma_wr_nbytes(dma_wr_nbytes),
  .buf_done(buf_done)
);

// ---- verification/tb_pixel_format_buffer_writer.sv ----
// Self-checking bench for the pixel format buffer writer
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_pixel_format_buffer_writer;
  timeunit 1ns;
  timeprecision 1ns;
  import pfbw_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic in_valid = 1'h0;
  logic in_color = 1'h0;
  logic in_cfa = 1'h0;
  pfbw_depth_type in_depth = PFBW_DEPTH_8;
  logic [47:0] in_data = 48'h0;
  logic [2:0] in_nbytes = 3'h0;
  logic in_sof = 1'h0;
  logic in_eol = 1'h0;
  logic in_eof = 1'h0;
  logic dma_wr_valid, buf_done;
  logic [31:0] dma_wr_addr, buf_done_base;
  logic [47:0] dma_wr_data;
  logic [2:0] dma_wr_nbytes;
  int bad_count = 0;
  int checked = 0;
  logic [47:0] da = {16'h0F0E, 16'h0123, 16'h0ABC};
  logic [47:0] db = {16'h0456, 16'h0789, 16'h0DEF};
  pfbw_top dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_color(in_color),
    .in_cfa(in_cfa), .in_depth(in_depth), .in_data(in_data),
    .in_nbytes(in_nbytes), .in_sof(in_sof), .in_eol(in_eol),
    .in_eof(in_eof), .dma_wr_valid(dma_wr_valid), .dma_wr_addr(dma_wr_addr),
    .dma_wr_data(dma_wr_data), .dma_wr_nbytes(dma_wr_nbytes),
    .buf_done(buf_done), .buf_done_base(buf_done_base));
  pfbw_host_mem host_u (.ref_clk(ref_clk), .dma_wr_valid(dma_wr_valid),
    .dma_wr_addr(dma_wr_addr), .dma_wr_data(dma_wr_data),
    .dma_wr_nbytes(dma_wr_nbytes), .buf_done(buf_done),
    .buf_done_base(buf_done_base));
  initial
    forever #25 ref_clk = ~ref_clk;
  // ==========================================================
  // Bus and stream tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // Length and stride only move between frames, with no buffer open
  task automatic cfg(input logic [6:0] c, input logic [31:0] ln, st, sz);
    wr(PFBW_OFF_CTRL, {25'h0, c});
    wr(PFBW_OFF_ROW_LEN, ln);
    wr(PFBW_OFF_ROW_STRIDE, st);
    wr(PFBW_OFF_BUF_BASE, 32'h0);
    wr(PFBW_OFF_BUF_SIZE, sz);
    host_u.clear();
  endtask
  task automatic pix(input logic [47:0] d, input logic s, l, f);
    in_valid <= 1'h1;
    in_data <= d;
    in_sof <= s;
    in_eol <= l;
    in_eof <= f;
    @(posedge ref_clk);
  endtask
  task automatic idle();
    in_valid <= 1'h0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic cmp(input logic [7:0] a, input logic [47:0] v, input int n);
    for (int k = 0; k < n; k++)
      `CHK("mem byte", v[8*k +: 8], host_u.mem[8'(a + k)])
  endtask
  function automatic logic [47:0] pk(input logic [15:0] a, b, c, input int n);
    if (n == 1)
      return {24'h0, c[7:0], b[7:0], a[7:0]};
    return {c, b, a};
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] v;
    rd(PFBW_OFF_CTRL, v);
    `CHK("ctrl", 32'h0, v)
    rd(8'h40, v);
    `CHK("unmapped", 32'h0, v)
    $display("test reset done");
  endtask
  task automatic t_align();
    pfbw_depth_type dl [5] = '{PFBW_DEPTH_8, PFBW_DEPTH_10, PFBW_DEPTH_12,
      PFBW_DEPTH_14, PFBW_DEPTH_16};
    int wl [5] = '{8, 10, 12, 14, 16};
    int nb;
    int sh;
    logic [15:0] m, c0, c1, c2;
    for (int md = 0; md < 2; md++)
      for (int i = 0; i < 5; i++)
      begin
        nb = (wl[i] == 8) ? 1 : 2;
        m = 16'hFFFF >> (16 - wl[i]);
        c0 = 16'h2A5B & m;
        c1 = 16'h1234 & m;
        c2 = 16'hC3F1 & m;
        cfg(7'(md << 2), 32'(6 * nb), 32'h0, 32'h40);
        in_color <= 1'h1;
        in_cfa <= 1'h0;
        in_depth <= dl[i];
        pix({c2, c1, c0}, 1'h1, 1'h0, 1'h0);
        pix({c0, c2, c1}, 1'h0, 1'h1, 1'h1);
        idle();
        sh = (md == 1 && nb == 2) ? 16 - wl[i] : 0;
        cmp(8'h00, pk(c0 << sh, c1 << sh, c2 << sh, nb), 3 * nb);
        cmp(8'(3 * nb), pk(c1 << sh, c2 << sh, c0 << sh, nb), 3 * nb);
      end
    $display("test align done");
  endtask
  task automatic t_swap();
    logic [6:0] cl [4] = '{7'h10, 7'h15, 7'h06, 7'h10};
    logic [47:0] ex;
    // Last case: decoder off, so a CFA beat is one component, never swapped
    for (int i = 0; i < 4; i++)
    begin
      cfg(cl[i], 32'hC, 32'h0, 32'h40);
      in_color <= 1'(i == 0);
      in_cfa <= 1'(i != 0);
      in_depth <= PFBW_DEPTH_12;
      pix(da, 1'h1, 1'h0, 1'h0);
      pix(da, 1'h0, 1'h1, 1'h1);
      idle();
      ex = (i < 2) ? {da[15:0], da[31:16], da[47:32]} : da;
      if (i == 3)
        ex = {16'hEEEE, da[15:0], da[15:0]};
      cmp(8'h00, ex, 6);
    end
    $display("test swap done");
  endtask
  task automatic t_raw();
    cfg(7'h08, 32'hA, 32'h0, 32'h40);
    in_color <= 1'h0;
    in_cfa <= 1'h0;
    in_depth <= PFBW_DEPTH_10;
    in_nbytes <= 3'h5;
    pix(48'h0012_3456_789A, 1'h1, 1'h0, 1'h0);
    pix(48'h00A1_B2C3_D4E5, 1'h0, 1'h1, 1'h1);
    idle();
    cmp(8'h00, 48'h0012_3456_789A, 5);
    cmp(8'h05, 48'h00A1_B2C3_D4E5, 5);
    $display("test raw done");
  endtask
  task automatic t_lines(input logic [6:0] c);
    for (int i = 0; i < 2; i++)
    begin
      cfg(c, 32'h6, i ? 32'h0 : 32'h10, 32'h28);
      in_color <= 1'h1;
      in_depth <= PFBW_DEPTH_16;
      pix(da, 1'h1, 1'h1, 1'h0);
      pix(db, 1'h0, 1'h1, 1'h1);
      idle();
      if (c == 7'h00)
      begin
        cmp(i ? 8'h06 : 8'h10, db, 6);
        if (i == 0)
          `CHK("pad byte", 8'hEE, host_u.mem[6])
      end
      else
      begin
        cmp(i ? 8'h1E : 8'h20, da, 6);
        cmp(i ? 8'h18 : 8'h10, db, 6);
      end
    end
    $display("test lines done");
  endtask
  task automatic t_drop();
    int n0;
    logic [31:0] v;
    cfg(7'h00, 32'hC, 32'h0, 32'h8);
    n0 = host_u.done_cnt;
    pix(da, 1'h1, 1'h0, 1'h0);
    pix(db, 1'h0, 1'h1, 1'h1);
    idle();
    cmp(8'h00, da, 6);
    `CHK("beyond end", 8'hEE, host_u.mem[8])
    `CHK("done count", n0 + 1, host_u.done_cnt)
    rd(PFBW_OFF_STATUS, v);
    `CHK("drop flag", 1'h1, v[PFBW_STAT_DROP_BIT])
    wr(PFBW_OFF_STATUS, 32'h1);
    rd(PFBW_OFF_STATUS, v);
    `CHK("drop cleared", 1'h0, v[PFBW_STAT_DROP_BIT])
    $display("test drop done");
  endtask
  task automatic t_lscan();
    int n0;
    cfg(7'h40, 32'h6, 32'h0, 32'hC);
    n0 = host_u.done_cnt;
    pix(da, 1'h1, 1'h1, 1'h0);
    pix(db, 1'h0, 1'h1, 1'h0);
    idle();
    wr(PFBW_OFF_BUF_BASE, 32'h40);
    pix(da, 1'h0, 1'h1, 1'h0);
    idle();
    `CHK("full release", n0 + 1, host_u.done_cnt)
    `CHK("full base", 32'h0, host_u.last_base)
    pix(db, 1'h0, 1'h1, 1'h1);
    idle();
    `CHK("last release", n0 + 2, host_u.done_cnt)
    `CHK("last base", 32'h40, host_u.last_base)
    cmp(8'h06, db, 6);
    cmp(8'h40, da, 6);
    cmp(8'h46, db, 6);
    $display("test line scan done");
  endtask
  // ==========================================================
  // Run control
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    t_reset();
    t_align();
    t_swap();
    t_raw();
    t_lines(7'h00);
    t_lines(7'h20);
    t_drop();
    t_lscan();
    complete_run();
  end
  // Tests take well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    complete_run();
  end
endmodule
